// *** mfc_core_model.sv ***
// Purpose: Processor-side partner: period strobes, J/K bus, interrupt
// Assumes: Each period lasts two cycles, strobe in the first
// Notes: PU0-PU7 then BP0-BP7 make one 32-cycle instruction
`timescale 1ns/1ps
`default_nettype none
module mfc_core_model (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Synchronous reset, low
  input wire logic [11:0] jVal, // J accumulator
  input wire logic [11:0] kVal, // K accumulator
  input wire logic irqReq, // Raise an interrupt
  output var mfc_pkg::mfc_timing_t timing, // Period strobes
  output logic [11:0] accData, // Accumulator bus
  output logic irq_pending_n // Interrupt pending, low
);
  logic [4:0] step_reg, step_next;
  logic pend_reg, pend_next;
  mfc_pkg::mfc_timing_t timing_next;

  // Next strobe; pending held from PU7 through PU1
  always_comb begin
    step_next = step_reg + 5'h01;
    timing_next.puStrobe = ~step_reg[0] & ~step_reg[4];
    timing_next.bpStrobe = ~step_reg[0] & step_reg[4];
    timing_next.phase = step_reg[3:1];
    pend_next = pend_reg;
    if (timing_next.puStrobe && timing_next.phase == mfc_pkg::PH_7) begin
      pend_next = ~irqReq;
    end else if (timing_next.puStrobe && timing_next.phase == 3'h2) begin
      pend_next = 1'b1;
    end
  end

  // Registers only; no strobe while reset is low
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      step_reg <= 5'h00;
      timing <= '0;
      pend_reg <= 1'b1;
    end else begin
      step_reg <= step_next;
      timing <= timing_next;
      pend_reg <= pend_next;
    end
  end

  assign irq_pending_n = pend_reg;
  // Bus is junk outside BP5/BP6 so stale values cannot pass
  assign accData = (timing.bpStrobe && timing.phase == mfc_pkg::PH_5) ? jVal :
    (timing.bpStrobe && timing.phase == mfc_pkg::PH_6) ? kVal : ~kVal;
endmodule // mfc_core_model
`default_nettype wire

// *** mfc_field_ctrl.sv ***
// Purpose: Memory field save, restore and select beside the processor core
// Assumes: Core, timing and peripheral logic share clk_sys; panel pins do not
// Notes: Field select bit 0 is the least significant field bit
`timescale 1ns/1ps
`default_nettype none

module mfc_field_ctrl (
  input wire logic clk_sys, // 125 MHz system clock
  input wire logic reset_n, // Synchronous reset
  input wire mfc_pkg::mfc_timing_t timing, // Period strobes
  input wire mfc_pkg::mfc_instr_t instr, // Instruction qualifiers
  input wire logic [11:0] addrReg, // Processor address register
  input wire logic [11:0] accData, // J at BP5, K at BP6
  input wire logic callSave, // Subroutine call save strobe
  input wire logic irq_pending_n, // Interrupt pending, low
  input wire logic steal_cycle_n, // Cycle steal flag, low
  input wire logic ext_field_bit0, // Peripheral field bit 0
  input wire logic ext_field_bit1, // Peripheral field bit 1
  input wire logic panel_load_request, // Panel load, async pin
  input wire logic panelEnable, // Panel controls on, async pin
  input wire logic [1:0] panelFieldSw, // Field switches, async pins
  output logic field_select_bit0, // Field select bit 0
  output logic field_select_bit1, // Field select bit 1
  output logic cur_field_bit0, // Memory field bit 0
  output logic cur_field_bit1, // Memory field bit 1
  output logic sub_return_match, // Subroutine return match
  output logic irq_return_match, // Interrupt return match
  output logic any_match_n, // Either match, low
  output logic [11:0] subRetAddr, // Subroutine return address
  output logic [11:0] irqRetAddr // Interrupt return address
);

  // Load op decode, shared by logic and checks
  function automatic logic isLoadRegs(input mfc_pkg::mfc_instr_t i);
    isLoadRegs = i.ioGroup && i.singleWord && i.haltGroup && i.bit7 &&
                 !i.bit10 && !i.bit11;
  endfunction

  // Panel pins are asynchronous: two flip-flops each
  logic [3:0] panelMeta_reg;
  logic [3:0] panelSync_reg;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      panelMeta_reg <= 4'h0;
      panelSync_reg <= 4'h0;
    end else begin
      panelMeta_reg <= {panel_load_request, panelEnable, panelFieldSw};
      panelSync_reg <= panelMeta_reg;
    end
  end

  logic panelLoad;
  assign panelLoad = panelSync_reg[3] && panelSync_reg[2];

  // State registers
  logic [1:0] memField_reg, memField_next;
  logic [1:0] subField_reg, subField_next;
  logic [1:0] irqField_reg, irqField_next;
  logic [11:0] subAddr_reg, subAddr_next;
  logic [11:0] irqAddr_reg, irqAddr_next;
  logic subMatch_reg, subMatch_next;
  logic irqMatch_reg, irqMatch_next;
  logic stealSel_reg, stealSel_next;
  logic [1:0] fieldSel_reg, fieldSel_next;
  mfc_pkg::mfc_irq_state_t irqState_reg, irqState_next;

  logic pu0, pu1, bp1, bp5, bp6, bp7, addrHit, loadOp;
  assign pu0 = timing.puStrobe && timing.phase == mfc_pkg::PH_0;
  assign pu1 = timing.puStrobe && timing.phase == mfc_pkg::PH_1;
  assign bp1 = timing.bpStrobe && timing.phase == mfc_pkg::PH_1;
  assign bp5 = timing.bpStrobe && timing.phase == mfc_pkg::PH_5;
  assign bp6 = timing.bpStrobe && timing.phase == mfc_pkg::PH_6;
  assign bp7 = timing.bpStrobe && timing.phase == mfc_pkg::PH_7;
  assign loadOp = isLoadRegs(instr);
  // Qualifier also checks the end addresses itself, so a core that
  // forgets the location flag still cannot fake a return
  assign addrHit = instr.indirectFlag && instr.ordinaryLocationN &&
                   addrReg != mfc_pkg::ADDR_LOWEST &&
                   addrReg != mfc_pkg::ADDR_HIGHEST;

  // Next-state logic for all field and address state except the output field select
  always_comb begin
    memField_next = memField_reg;
    subField_next = subField_reg;
    irqField_next = irqField_reg;
    subAddr_next = subAddr_reg;
    irqAddr_next = irqAddr_reg;
    subMatch_next = subMatch_reg;
    irqMatch_next = irqMatch_reg;
    stealSel_next = stealSel_reg;
    irqState_next = irqState_reg;
    if (callSave) begin
      subField_next = memField_reg;
    end
    // Match flags; load op leaves the field alone
    if (bp1) begin
      subMatch_next = 1'b0;
      irqMatch_next = 1'b0;
    end
    if (bp5 && addrHit && subAddr_reg == addrReg) begin
      subMatch_next = 1'b1;
    end
    if (bp6 && addrHit && irqAddr_reg == addrReg) begin
      irqMatch_next = 1'b1;
    end
    // Return registers: load op, clear on return, interrupt save
    if (bp5 && loadOp) begin
      subAddr_next = accData;
    end
    if (bp6 && loadOp) begin
      irqAddr_next = accData;
    end
    if (bp7 && instr.isJump && subMatch_reg) begin
      subAddr_next = mfc_pkg::ADDR_RESET;
    end
    if (bp7 && instr.isJump && irqMatch_reg) begin
      irqAddr_next = mfc_pkg::ADDR_RESET;
    end
    // Memory field register; a steal never writes it
    if (pu0 && panelLoad) begin
      memField_next = panelSync_reg[1:0];
    end else if (pu0 && instr.isJump && irqMatch_reg) begin
      memField_next = irqField_reg;
    end else if (pu0 && instr.isJump && subMatch_reg) begin
      memField_next = subField_reg;
    end
    // Interrupt initiation sequence
    case (irqState_reg)
      mfc_pkg::IRQ_IDLE: begin
        if (pu0 && !irq_pending_n) begin
          irqState_next = mfc_pkg::IRQ_SEL_ZERO;
        end
      end
      mfc_pkg::IRQ_SEL_ZERO: begin
        if (pu1) begin
          irqAddr_next = addrReg;
          irqField_next = memField_reg;
          memField_next = mfc_pkg::FIELD_ZERO;
          irqState_next = mfc_pkg::IRQ_HOLD;
        end
      end
      mfc_pkg::IRQ_HOLD: begin
        if (pu1) begin
          irqState_next = mfc_pkg::IRQ_IDLE;
        end
      end
      default: begin
        irqState_next = mfc_pkg::IRQ_IDLE;
      end
    endcase
    // Steal select is only a routing flag
    if (pu0 && !steal_cycle_n) begin
      stealSel_next = 1'b1;
    end else if (pu1 && steal_cycle_n) begin
      stealSel_next = 1'b0;
    end
  end

  // Output field mux; bit 0 is the low index bit
  always_comb begin
    if (irqState_next == mfc_pkg::IRQ_SEL_ZERO) begin
      fieldSel_next = mfc_pkg::FIELD_ZERO;
    end else if (stealSel_next) begin
      fieldSel_next = {ext_field_bit1, ext_field_bit0};
    end else begin
      fieldSel_next = memField_next;
    end
  end

  // Register every state group
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      memField_reg <= mfc_pkg::FIELD_ZERO;
      subField_reg <= mfc_pkg::FIELD_ZERO;
      irqField_reg <= mfc_pkg::FIELD_ZERO;
      subAddr_reg <= mfc_pkg::ADDR_RESET;
      irqAddr_reg <= mfc_pkg::ADDR_RESET;
      subMatch_reg <= 1'b0;
      irqMatch_reg <= 1'b0;
      stealSel_reg <= 1'b0;
      fieldSel_reg <= mfc_pkg::FIELD_ZERO;
      irqState_reg <= mfc_pkg::IRQ_IDLE;
    end else begin
      memField_reg <= memField_next;
      subField_reg <= subField_next;
      irqField_reg <= irqField_next;
      subAddr_reg <= subAddr_next;
      irqAddr_reg <= irqAddr_next;
      subMatch_reg <= subMatch_next;
      irqMatch_reg <= irqMatch_next;
      stealSel_reg <= stealSel_next;
      fieldSel_reg <= fieldSel_next;
      irqState_reg <= irqState_next;
    end
  end

  // Outputs straight from flip-flops
  assign field_select_bit0 = fieldSel_reg[0];
  assign field_select_bit1 = fieldSel_reg[1];
  assign cur_field_bit0 = memField_reg[0];
  assign cur_field_bit1 = memField_reg[1];
  assign sub_return_match = subMatch_reg;
  assign irq_return_match = irqMatch_reg;
  assign subRetAddr = subAddr_reg;
  assign irqRetAddr = irqAddr_reg;
  logic anyMatchN_reg;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      anyMatchN_reg <= 1'b1;
    end else begin
      anyMatchN_reg <= !(subMatch_next || irqMatch_next);
    end
  end
  assign any_match_n = anyMatchN_reg;

  // Checks
  sequence s_irqStart;
    pu0 && !irq_pending_n && irqState_reg == mfc_pkg::IRQ_IDLE;
  endsequence
  sequence s_irqSave;
    pu1 && irqState_reg == mfc_pkg::IRQ_SEL_ZERO;
  endsequence

  property p_bp1Clear;
    @(posedge clk_sys) disable iff (!reset_n)
      bp1 && !bp5 && !bp6 |=> !sub_return_match && !irq_return_match;
  endproperty
  a_bp1Clear: assert property (p_bp1Clear)
    else $error("match flag survived BP1");

  property p_irqZero;
    @(posedge clk_sys) disable iff (!reset_n)
      s_irqStart |=> {field_select_bit1, field_select_bit0} == 2'h0;
  endproperty
  a_irqZero: assert property (p_irqZero)
    else $error("field zero not selected at interrupt start");

  property p_irqSave;
    @(posedge clk_sys) disable iff (!reset_n)
      s_irqSave |=> irqRetAddr == $past(addrReg) &&
        irqField_reg == $past(memField_reg) &&
        {cur_field_bit1, cur_field_bit0} == 2'h0;
  endproperty
  a_irqSave: assert property (p_irqSave)
    else $error("interrupt save at PU1 wrong");

  property p_irqRelease;
    @(posedge clk_sys) disable iff (!reset_n)
      pu1 && irqState_reg == mfc_pkg::IRQ_HOLD && !stealSel_next |=>
        irqState_reg == mfc_pkg::IRQ_IDLE &&
        fieldSel_reg == memField_reg;
  endproperty
  a_irqRelease: assert property (p_irqRelease)
    else $error("field selection not returned at next PU1");

  property p_noEndMatch;
    @(posedge clk_sys) disable iff (!reset_n)
      (bp5 || bp6) && (addrReg == 12'h000 || addrReg == 12'hFFF) &&
        !bp1 |=> $stable(irq_return_match) && $stable(sub_return_match);
  endproperty
  a_noEndMatch: assert property (p_noEndMatch)
    else $error("match raised on end address");

  property p_irqMatch;
    @(posedge clk_sys) disable iff (!reset_n)
      bp6 && instr.indirectFlag && instr.ordinaryLocationN &&
        irqRetAddr == addrReg && addrReg != 12'h000 && addrReg != 12'hFFF
        |=> irq_return_match;
  endproperty
  a_irqMatch: assert property (p_irqMatch)
    else $error("interrupt match not set at BP6");

  property p_irqReturn;
    @(posedge clk_sys) disable iff (!reset_n)
      bp7 && instr.isJump && irqMatch_reg && !loadOp |=> irqRetAddr == 12'h000;
  endproperty
  a_irqReturn: assert property (p_irqReturn)
    else $error("interrupt return address not cleared");

  property p_subRestore;
    @(posedge clk_sys) disable iff (!reset_n)
      pu0 && instr.isJump && subMatch_reg && !irqMatch_reg && !panelLoad
        |=> memField_reg == $past(subField_reg);
  endproperty
  a_subRestore: assert property (p_subRestore)
    else $error("subroutine field not restored");

  property p_steal;
    @(posedge clk_sys) disable iff (!reset_n)
      pu0 && !steal_cycle_n && irq_pending_n |=>
        fieldSel_reg == $past({ext_field_bit1, ext_field_bit0});
  endproperty
  a_steal: assert property (p_steal)
    else $error("steal field not routed");

  property p_loadJ;
    @(posedge clk_sys) disable iff (!reset_n)
      bp5 && loadOp && !bp7 |=> subRetAddr == $past(accData) ##0
        $stable(memField_reg);
  endproperty
  a_loadJ: assert property (p_loadJ)
    else $error("J not captured at BP5");

endmodule // mfc_field_ctrl

`default_nettype wire

// *** mfc_pkg.sv ***
// Purpose: Shared constants and types for the memory field control block
// Assumes: 12-bit addresses, two-bit field numbers, 8-step phase counts
// Notes: Phase numbers name the basic-phase and update periods
package mfc_pkg;

  localparam int ADDR_W = 12;
  localparam int FIELD_W = 2;
  localparam int PHASE_W = 3;

  // Phase numbers used by the block
  localparam logic [PHASE_W-1:0] PH_0 = 3'h0;
  localparam logic [PHASE_W-1:0] PH_1 = 3'h1;
  localparam logic [PHASE_W-1:0] PH_5 = 3'h5;
  localparam logic [PHASE_W-1:0] PH_6 = 3'h6;
  localparam logic [PHASE_W-1:0] PH_7 = 3'h7;

  // Reset values and special addresses
  localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_LOWEST = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_HIGHEST = 12'hFFF;
  localparam logic [FIELD_W-1:0] FIELD_ZERO = 2'h0;

  // Interrupt field sequence
  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b00,
    IRQ_SEL_ZERO = 2'b01,
    IRQ_HOLD = 2'b10
  } mfc_irq_state_t;

  // Processor timing: one-cycle strobes plus the period number
  typedef struct packed {
    logic bpStrobe;
    logic puStrobe;
    logic [PHASE_W-1:0] phase;
  } mfc_timing_t;

  // Instruction qualifiers from the processor
  typedef struct packed {
    logic isJump;
    logic indirectFlag;
    logic ordinaryLocationN;
    logic ioGroup;
    logic singleWord;
    logic haltGroup;
    logic bit7;
    logic bit10;
    logic bit11;
  } mfc_instr_t;

endpackage

// *** tb_top.sv ***
// Purpose: Self-checking bench for the memory field control block
// Assumes: Core model supplies strobes, accumulators and interrupt
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys, reset_n, callSave, steal_cycle_n, irqReq, irq_pending_n;
  logic ext_field_bit0, ext_field_bit1, panel_load_request, panelEnable;
  logic field_select_bit0, field_select_bit1, cur_field_bit0, cur_field_bit1;
  logic sub_return_match, irq_return_match, any_match_n;
  logic [1:0] panelFieldSw;
  logic [11:0] addrReg, accData, jVal, kVal, subRetAddr, irqRetAddr;
  mfc_pkg::mfc_timing_t timing;
  mfc_pkg::mfc_instr_t instr;
  int error_cnt, n_compared, cycles;

  mfc_core_model core (.clk_sys(clk_sys), .reset_n(reset_n), .jVal(jVal),
    .kVal(kVal), .irqReq(irqReq), .timing(timing), .accData(accData),
    .irq_pending_n(irq_pending_n));
  mfc_field_ctrl dut (.clk_sys(clk_sys), .reset_n(reset_n), .timing(timing),
    .instr(instr), .addrReg(addrReg), .accData(accData), .callSave(callSave),
    .irq_pending_n(irq_pending_n), .steal_cycle_n(steal_cycle_n),
    .ext_field_bit0(ext_field_bit0), .ext_field_bit1(ext_field_bit1),
    .panel_load_request(panel_load_request), .panelEnable(panelEnable),
    .panelFieldSw(panelFieldSw), .field_select_bit0(field_select_bit0),
    .field_select_bit1(field_select_bit1), .cur_field_bit0(cur_field_bit0),
    .cur_field_bit1(cur_field_bit1), .sub_return_match(sub_return_match),
    .irq_return_match(irq_return_match), .any_match_n(any_match_n),
    .subRetAddr(subRetAddr), .irqRetAddr(irqRetAddr));

  // Clock at 8 ns
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [11:0] sel();
    return {10'h000, field_select_bit1, field_select_bit0};
  endfunction
  function automatic logic [11:0] cur();
    return {10'h000, cur_field_bit1, cur_field_bit0};
  endfunction
  // Packs sub flag, irq flag, combined low flag
  function automatic logic [11:0] flags();
    return {9'h000, sub_return_match, irq_return_match, any_match_n};
  endfunction

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait for a strobe, then let its results land
  task automatic per(input logic pu, input logic [2:0] ph);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!((pu ? timing.puStrobe : timing.bpStrobe) &&
      timing.phase == ph) && n < 80);
    if (n >= 80) begin
      error_cnt++;
      $display("BAD t=%0t no strobe %h %h", $time, pu, ph);
    end
    #1;
  endtask

  // Set after a PU0 so the panel sync settles before the next one
  task automatic panel(input logic en, input logic [1:0] sw);
    panelEnable = en;
    panelFieldSw = sw;
    panel_load_request = 1'b1;
    per(1'b1, mfc_pkg::PH_0);
    panel_load_request = 1'b0;
  endtask

  task automatic loadop(input logic [11:0] j, k, input logic b10);
    jVal = j;
    kVal = k;
    instr = mfc_pkg::mfc_instr_t'({7'h0F, b10, 1'b0});
    per(1'b0, mfc_pkg::PH_6);
    @(posedge clk_sys);
    #1 instr = mfc_pkg::mfc_instr_t'(9'h000);
  endtask

  // Indirect jump through a; result seen at the flag period
  task automatic jmp(input logic [11:0] a, input logic [2:0] ph);
    addrReg = a;
    instr = mfc_pkg::mfc_instr_t'((a == 12'h000 || a == 12'hFFF) ?
      9'h180 : 9'h1C0);
    per(1'b0, ph);
  endtask

  task automatic end_of_test();
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard, well above the roughly 500 cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    {error_cnt, n_compared, cycles} = '0;
    {reset_n, callSave, irqReq, ext_field_bit0, ext_field_bit1} = '0;
    {panel_load_request, panelEnable, panelFieldSw} = '0;
    {addrReg, jVal, kVal} = '0;
    steal_cycle_n = 1'b1;
    instr = mfc_pkg::mfc_instr_t'(9'h000);
    repeat (12) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    chk(cur(), 12'h000);
    chk(flags(), 12'h001);
    chk(irqRetAddr | subRetAddr, 12'h000);
    // Panel: refused while disabled, then loads
    per(1'b1, mfc_pkg::PH_0);
    panel(1'b0, 2'h3);
    per(1'b1, mfc_pkg::PH_0);
    chk(cur(), 12'h000);
    panel(1'b1, 2'h1);
    per(1'b1, mfc_pkg::PH_0);
    chk(cur(), 12'h001);
    chk(sel(), 12'h001);
    callSave = 1'b1;
    @(posedge clk_sys);
    #1 callSave = 1'b0;
    panel(1'b1, 2'h2);
    per(1'b1, mfc_pkg::PH_0);
    chk(cur(), 12'h002);
    // Register load: wrong bit 10 ignored, then J and K captured
    loadop(12'h456, 12'h321, 1'b1);
    chk(subRetAddr | irqRetAddr, 12'h000);
    loadop(12'h456, 12'h321, 1'b0);
    chk(subRetAddr, 12'h456);
    chk(irqRetAddr, 12'h321);
    chk(cur(), 12'h002);
    // Interrupt initiation saves field 2
    addrReg = 12'h123;
    irqReq = 1'b1;
    per(1'b1, mfc_pkg::PH_7);
    irqReq = 1'b0;
    per(1'b1, mfc_pkg::PH_0);
    chk(sel(), 12'h000);
    per(1'b1, mfc_pkg::PH_1);
    chk(irqRetAddr, 12'h123);
    chk(cur(), 12'h000);
    per(1'b1, mfc_pkg::PH_1);
    chk(sel(), 12'h000);
    // Subroutine return restores field 1
    jmp(12'h456, mfc_pkg::PH_5);
    chk(flags(), 12'h004);
    per(1'b1, mfc_pkg::PH_0);
    chk(cur(), 12'h001);
    per(1'b0, mfc_pkg::PH_1);
    chk(flags(), 12'h001);
    // Interrupt return restores field 2
    jmp(12'h123, mfc_pkg::PH_6);
    chk(flags(), 12'h002);
    per(1'b0, mfc_pkg::PH_7);
    chk(irqRetAddr, 12'h000);
    per(1'b1, mfc_pkg::PH_0);
    chk(cur(), 12'h002);
    per(1'b0, mfc_pkg::PH_1);
    chk(flags(), 12'h001);
    // End addresses never match
    loadop(12'hFFF, 12'h000, 1'b0);
    jmp(12'h000, mfc_pkg::PH_7);
    chk(flags(), 12'h001);
    jmp(12'hFFF, mfc_pkg::PH_7);
    chk(flags(), 12'h001);
    // Cycle steal with peripheral field, then back to field 2
    instr = mfc_pkg::mfc_instr_t'(9'h000);
    {steal_cycle_n, ext_field_bit1, ext_field_bit0} = 3'h1;
    per(1'b1, mfc_pkg::PH_0);
    chk(sel(), 12'h001);
    ext_field_bit1 = 1'b1;
    @(posedge clk_sys);
    #1 chk(sel(), 12'h003);
    steal_cycle_n = 1'b1;
    chk(cur(), 12'h002);
    chk(subRetAddr, 12'hFFF);
    per(1'b1, mfc_pkg::PH_1);
    chk(sel(), 12'h002);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
